// ### hw/uig_pkg.sv
// package: register map, field positions, timing and carriers of the event gating block
package uig_pkg;
   // ******
   // register byte addresses
   // ******
   localparam logic [31:0] UIG_HOLDOFF_ADDR = 32'h0000_0094;
   localparam logic [31:0] UIG_MASK_ADDR    = 32'h0000_0098;
   localparam logic [31:0] UIG_PEND_ADDR    = 32'h0000_0100;
   // values after reset, writable bits and event bits
   localparam logic [15:0] UIG_HOLDOFF_RST  = 16'h0800;
   localparam logic [31:0] UIG_MASK_RST     = 32'h0000_0000;
   localparam logic [31:0] UIG_MASK_WMASK   = 32'h97FF_F0FF;
   localparam logic [31:0] UIG_EVT_BITS     = 32'h17FF_F0FF;
   // field positions in the event mask
   localparam int UIG_FORCE_POS    = 31;
   localparam int UIG_OTP_POS      = 28;
   localparam int UIG_LP_ENTRY_POS = 26;
   localparam int UIG_LP_EXIT_POS  = 25;
   localparam int UIG_LP_RX_POS    = 24;
   localparam int UIG_MRTO_POS     = 23;
   localparam int UIG_RXOVF_POS    = 22;
   localparam int UIG_TXERR_POS    = 21;
   localparam int UIG_LINK_POS     = 20;
   localparam int UIG_TXDIS_POS    = 19;
   localparam int UIG_RXDIS_POS    = 18;
   localparam int UIG_XCVR_POS     = 17;
   localparam int UIG_DPORT_POS    = 16;
   localparam int UIG_MACERR_POS   = 15;
   localparam int UIG_UNDERRUN_POS = 14;
   localparam int UIG_OVERRUN_POS  = 13;
   localparam int UIG_FPEND_POS    = 12;
   localparam int UIG_PIN_LSB      = 0;
   // ******
   // timing: hold-off step and clock period
   // ******
   localparam real         UIG_STEP_NS = 16.667;
   localparam real         UIG_CLK_NS  = 10.0;
   localparam logic [14:0] UIG_STEP_PS = 15'(int'(UIG_STEP_NS * 1000.0));
   localparam logic [14:0] UIG_CLK_PS  = 15'(int'(UIG_CLK_NS * 1000.0));
   // ******
   // carriers
   // ******
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
   } uig_ahb_req_t;
   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } uig_ahb_rsp_t;
   localparam uig_ahb_rsp_t UIG_RSP_RST = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
   typedef struct packed {
      logic       otp_write_done;
      logic       lowpower_tx_entry;
      logic       lowpower_tx_exit;
      logic       lowpower_rx;
      logic       mac_reset_timeout;
      logic       rx_fifo_overflow;
      logic       transmit_error;
      logic       transmit_disabled;
      logic       receive_disabled;
      logic       transceiver_irq;
      logic       data_port;
      logic       mac_error;
      logic       tx_fifo_underrun;
      logic       tx_fifo_overrun;
      logic       frame_pending;
      logic [7:0] pin_event;
   } uig_evt_t;
   typedef struct packed {
      logic        send;
      logic        nak;
      logic [31:0] events;
   } uig_report_t;
endpackage

// ### hw/uig_ahb_port.sv
// ahb-lite slave front end: zero wait states, always okay
`timescale 1ns/10ps
`default_nettype none
module uig_ahb_port
(
   input  wire logic                  clk_in,       // block clock
   input  wire logic                  rst_in,       // async reset, high
   input  wire uig_pkg::uig_ahb_req_t req_in,       // bus request
   input  wire logic [31:0]           rd_data_in,   // read value of rd_addr_out
   output var  logic                  wr_en_out,    // write in data phase
   output var  logic [31:0]           wr_addr_out,  // address of that write
   output var  logic [31:0]           wr_data_out,  // write data
   output var  logic [31:0]           rd_addr_out,  // address phase address
   output var  uig_pkg::uig_ahb_rsp_t rsp_out       // bus response
);
   import uig_pkg::*;
   logic         take;
   logic         wr_q, wr_d;
   logic [31:0]  addr_q, addr_d;
   uig_ahb_rsp_t rsp_q, rsp_d;

   // address phase decode; read data captured for the data phase
   always_comb
   begin
      take = req_in.hsel && req_in.htrans[1] && rsp_q.hreadyout;
      wr_d = take && req_in.hwrite;
      addr_d = take ? req_in.haddr : addr_q;
      rsp_d = UIG_RSP_RST;
      if (take && !req_in.hwrite)
      begin
         rsp_d.hrdata = rd_data_in;
      end
   end

   // registers
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_q   <= 1'b0;
         addr_q <= 32'h0000_0000;
         rsp_q  <= UIG_RSP_RST;
      end
      else
      begin
         wr_q   <= wr_d;
         addr_q <= addr_d;
         rsp_q  <= rsp_d;
      end
   end

   assign wr_en_out   = wr_q;
   assign wr_addr_out = addr_q;
   assign wr_data_out = req_in.hwdata;
   assign rd_addr_out = req_in.haddr;
   assign rsp_out     = rsp_q;
endmodule
`default_nettype wire

// ### hw/uig_holdoff.sv
// short packet hold-off timer counting delay steps on the block clock
`timescale 1ns/10ps
`default_nettype none
module uig_holdoff
(
   input  wire logic        clk_in,     // block clock
   input  wire logic        rst_in,     // async reset, high
   input  wire logic        req_in,     // sender wants a short packet
   input  wire logic [15:0] count_in,   // delay in steps
   output var  logic        grant_out   // hold-off elapsed
);
   import uig_pkg::*;
   typedef enum logic [1:0] {HO_IDLE, HO_WAIT, HO_GRANT} uig_ho_st_t;
   uig_ho_st_t  st_q, st_d;
   logic [14:0] acc_q, acc_d, sum;
   logic [16:0] steps_q, steps_d, cyc_q, cyc_d;
   logic [15:0] tgt_q, tgt_d;
   logic        grant_q, grant_d;

   // elapsed time kept in ps modulo one step
   always_comb
   begin
      st_d = st_q;
      acc_d = acc_q;
      steps_d = steps_q;
      cyc_d = cyc_q;
      tgt_d = tgt_q;
      sum = acc_q + UIG_CLK_PS;
      unique case (st_q)
         HO_IDLE:
         begin
            acc_d = 15'h0000;
            steps_d = 17'h0_0000;
            cyc_d = 17'h0_0000;
            tgt_d = count_in;
            if (req_in)
            begin
               st_d = (count_in == 16'h0000) ? HO_GRANT : HO_WAIT;
            end
         end
         HO_WAIT:
         begin
            if (!req_in)
            begin
               st_d = HO_IDLE;
            end
            else
            begin
               cyc_d = cyc_q + 17'h0_0001;
               acc_d = (sum >= UIG_STEP_PS) ? sum - UIG_STEP_PS : sum;
               steps_d = (sum >= UIG_STEP_PS) ? steps_q + 17'h0_0001 : steps_q;
               if (steps_d >= {1'b0, tgt_q})
               begin
                  st_d = HO_GRANT;
               end
            end
         end
         HO_GRANT:
         begin
            if (!req_in)
            begin
               st_d = HO_IDLE;
            end
         end
      endcase
      grant_d = (st_d == HO_GRANT);
   end

   // registers
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_q    <= HO_IDLE;
         acc_q   <= 15'h0000;
         steps_q <= 17'h0_0000;
         cyc_q   <= 17'h0_0000;
         tgt_q   <= 16'h0000;
         grant_q <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         acc_q   <= acc_d;
         steps_q <= steps_d;
         cyc_q   <= cyc_d;
         tgt_q   <= tgt_d;
         grant_q <= grant_d;
      end
   end

   assign grant_out = grant_q;

   // ******
   // checks
   // ******
   holdoff_least_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(grant_q) |-> 64'(cyc_q) * 64'(UIG_CLK_PS) >= 64'(tgt_q) * 64'(UIG_STEP_PS))
      else $error("short packet granted before hold-off elapsed");
   holdoff_most_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(grant_q) |-> 64'(cyc_q) * 64'(UIG_CLK_PS)
         < 64'(tgt_q) * 64'(UIG_STEP_PS) + 64'(UIG_CLK_PS))
      else $error("short packet grant later than one cycle past hold-off");
endmodule
`default_nettype wire

// ### hw/uig_top.sv
// interrupt endpoint event gating with short packet hold-off, ahb-lite registers
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module uig_top
(
   input  wire logic                  mclk_in,              // 100 MHz clock
   input  wire logic                  sys_rst_in,           // async reset, high
   input  wire uig_pkg::uig_ahb_req_t ahb_req_in,           // ahb-lite request
   output var  uig_pkg::uig_ahb_rsp_t ahb_rsp_out,          // ahb-lite response
   input  wire uig_pkg::uig_evt_t     events_in,            // event pulses
   input  wire logic [15:0]           link_change_in,       // link status change bits
   input  wire logic                  poll_in,              // host polls endpoint
   output var  uig_pkg::uig_report_t  report_out,           // packet or nak
   input  wire logic                  short_pkt_req_in,     // sender has short packet
   output var  logic                  short_pkt_grant_out   // short packet may go
);
   import uig_pkg::*;

   // ******
   // state
   // ******
   logic [15:0] holdoff_q;
   logic [15:0] holdoff_d;
   logic [31:0] mask_q;
   logic [31:0] mask_d;
   logic [31:0] pend_q;
   logic [31:0] pend_d;
   uig_report_t report_q;
   uig_report_t report_d;

   // bus side
   logic        wr_en;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;

   // event side
   logic [31:0] raw_evt;
   logic [31:0] gated_evt;
   logic        link_status_event_flag;
   logic        periodic_report_force;

   // ******
   // register bus
   // ******

   // ahb-lite slave, answers with no wait state
   uig_ahb_port u_bus
   (
      .clk_in      (mclk_in),
      .rst_in      (sys_rst_in),
      .req_in      (ahb_req_in),
      .rd_data_in  (rd_data),
      .wr_en_out   (wr_en),
      .wr_addr_out (wr_addr),
      .wr_data_out (wr_data),
      .rd_addr_out (rd_addr),
      .rsp_out     (ahb_rsp_out)
   );

   // ******
   // register file
   // ******

   // software writes; reserved bits are never stored
   always_comb
   begin
      holdoff_d = holdoff_q;
      mask_d = mask_q;
      if (wr_en && (wr_addr == UIG_HOLDOFF_ADDR))
      begin
         holdoff_d = wr_data[15:0];
      end
      if (wr_en && (wr_addr == UIG_MASK_ADDR))
      begin
         mask_d = wr_data & UIG_MASK_WMASK;
      end
   end

   // register storage
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         holdoff_q <= UIG_HOLDOFF_RST;
         mask_q    <= UIG_MASK_RST;
      end
      else
      begin
         holdoff_q <= holdoff_d;
         mask_q    <= mask_d;
      end
   end

   // read mux uses next hold-off and mask values so a read right after a write sees it; pending reads pend_q
   always_comb
   begin
      rd_data = 32'h0000_0000;
      case (rd_addr)
         UIG_HOLDOFF_ADDR:
         begin
            rd_data = {16'h0000, holdoff_d};
         end
         UIG_MASK_ADDR:
         begin
            rd_data = mask_d;
         end
         UIG_PEND_ADDR:
         begin
            rd_data = pend_q;
         end
         default:
         begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // ******
   // event gating
   // ******

   // place each event at the position of its enable
   always_comb
   begin
      raw_evt = 32'h0000_0000;
      link_status_event_flag = |link_change_in;
      raw_evt[UIG_OTP_POS] = events_in.otp_write_done;
      raw_evt[UIG_LP_ENTRY_POS] = events_in.lowpower_tx_entry;
      raw_evt[UIG_LP_EXIT_POS] = events_in.lowpower_tx_exit;
      raw_evt[UIG_LP_RX_POS] = events_in.lowpower_rx;
      raw_evt[UIG_MRTO_POS] = events_in.mac_reset_timeout;
      raw_evt[UIG_RXOVF_POS] = events_in.rx_fifo_overflow;
      raw_evt[UIG_TXERR_POS] = events_in.transmit_error;
      raw_evt[UIG_LINK_POS] = link_status_event_flag;
      raw_evt[UIG_TXDIS_POS] = events_in.transmit_disabled;
      raw_evt[UIG_RXDIS_POS] = events_in.receive_disabled;
      raw_evt[UIG_XCVR_POS] = events_in.transceiver_irq;
      raw_evt[UIG_DPORT_POS] = events_in.data_port;
      raw_evt[UIG_MACERR_POS] = events_in.mac_error;
      raw_evt[UIG_UNDERRUN_POS] = events_in.tx_fifo_underrun;
      raw_evt[UIG_OVERRUN_POS] = events_in.tx_fifo_overrun;
      raw_evt[UIG_FPEND_POS] = events_in.frame_pending;
      raw_evt[UIG_PIN_LSB +: 8] = events_in.pin_event;
   end

   // an event counts only where its enable is set
   assign gated_evt = raw_evt & mask_q & UIG_EVT_BITS;
   assign periodic_report_force = mask_q[UIG_FORCE_POS];

   // ******
   // interrupt endpoint reports
   // ******

   // a poll sends the latched events, or a nak when nothing is due;
   // an event in the poll cycle itself stays latched for the next poll
   always_comb
   begin
      report_d = '0;
      pend_d = pend_q;
      if (poll_in)
      begin
         if (periodic_report_force || (pend_q != 32'h0000_0000))
         begin
            report_d.send = 1'b1;
            report_d.events = pend_q;
            pend_d = 32'h0000_0000;
         end
         else
         begin
            report_d.nak = 1'b1;
         end
      end
      pend_d = pend_d | gated_evt;
   end

   // report and pending storage
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         pend_q   <= 32'h0000_0000;
         report_q <= '0;
      end
      else
      begin
         pend_q   <= pend_d;
         report_q <= report_d;
      end
   end

   assign report_out = report_q;

   // ******
   // short packet hold-off
   // ******

   // grant follows the programmed delay once the sender asks
   uig_holdoff u_holdoff
   (
      .clk_in    (mclk_in),
      .rst_in    (sys_rst_in),
      .req_in    (short_pkt_req_in),
      .count_in  (holdoff_q),
      .grant_out (short_pkt_grant_out)
   );

   // ******
   // checks
   // ******
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);

   mask_reserved_zero_a: assert property (
      (mask_q & ~UIG_MASK_WMASK) == 32'h0000_0000)
      else $error("reserved mask bit holds a one");

   holdoff_reset_val_a: assert property (
      $fell(sys_rst_in) |-> holdoff_q == UIG_HOLDOFF_RST)
      else $error("hold-off not at reset value");

   force_send_a: assert property (
      poll_in && periodic_report_force |=> report_q.send && !report_q.nak)
      else $error("forced report not sent on poll");

   idle_nak_a: assert property (
      poll_in && !periodic_report_force && pend_q == 32'h0000_0000
      |=> report_q.nak && !report_q.send)
      else $error("packet sent with nothing pending");

   event_latched_a: assert property (
      gated_evt != 32'h0000_0000
      |=> (pend_q & $past(gated_evt)) == $past(gated_evt))
      else $error("enabled event lost");

   report_content_a: assert property (
      poll_in && (pend_q != 32'h0000_0000) |=> report_q.send
      && report_q.events == $past(pend_q))
      else $error("report does not carry latched events");

   otp_gate_a: assert property (
      !mask_q[UIG_OTP_POS] && !pend_q[UIG_OTP_POS] |=> !pend_q[UIG_OTP_POS])
      else $error("masked otp event latched");

   link_status_a: assert property (
      (link_change_in != 16'h0000) && mask_q[UIG_LINK_POS] |=> pend_q[UIG_LINK_POS])
      else $error("link status change not latched");

   grant_release_a: assert property (
      !short_pkt_req_in |=> !short_pkt_grant_out)
      else $error("grant stands without a request");

   // register writes land one edge after the data phase
   mask_write_a: assert property (
      wr_en && (wr_addr == UIG_MASK_ADDR) |=> mask_q == ($past(wr_data) & UIG_MASK_WMASK))
      else $error("mask write not stored");

   holdoff_write_a: assert property (
      wr_en && (wr_addr == UIG_HOLDOFF_ADDR) |=> holdoff_q == $past(wr_data[15:0]))
      else $error("hold-off write not stored");

   mask_reset_a: assert property (
      $fell(sys_rst_in) |-> mask_q == UIG_MASK_RST)
      else $error("mask not at reset value");

   // reports only answer polls, one kind at a time
   quiet_no_poll_a: assert property (
      !poll_in |=> !report_q.send && !report_q.nak)
      else $error("report without a poll");

   send_nak_excl_a: assert property (
      !(report_q.send && report_q.nak))
      else $error("send and nak together");

   nak_empty_a: assert property (
      report_q.nak |-> report_q.events == 32'h0000_0000)
      else $error("nak carries events");

   // pending bits stay until a sending poll, which keeps only new events
   pend_kept_a: assert property (
      !poll_in |=> (pend_q & $past(pend_q)) == $past(pend_q))
      else $error("pending event dropped");

   poll_clears_a: assert property (
      poll_in && (periodic_report_force || pend_q != 32'h0000_0000)
      |=> pend_q == $past(gated_evt))
      else $error("pending not cleared by report");

   pend_reserved_a: assert property (
      (pend_q & ~UIG_EVT_BITS) == 32'h0000_0000)
      else $error("reserved pending bit set");

   // grant only follows a request and stands while it is held
   grant_rise_a: assert property (
      $rose(short_pkt_grant_out) |-> $past(short_pkt_req_in))
      else $error("grant without a request");

   grant_hold_a: assert property (
      short_pkt_grant_out && short_pkt_req_in |=> short_pkt_grant_out)
      else $error("grant dropped while requested");

   // a masked event bit never becomes pending
   for (genvar g = 0; g < 32; g++)
   begin : gate_chk
      if (UIG_EVT_BITS[g])
      begin : gate_bit
         bit_gate_a: assert property (
            !mask_q[g] && !pend_q[g] |=> !pend_q[g])
            else $error("masked event latched");
      end
   end

   forced_report_c: cover property (poll_in && periodic_report_force);
   event_report_c: cover property (poll_in && !periodic_report_force
      && pend_q != 32'h0000_0000);
   nak_c: cover property (poll_in && pend_q == 32'h0000_0000);
   grant_c: cover property ($rose(short_pkt_grant_out));
   set_wins_c: cover property (poll_in && gated_evt != 32'h0000_0000);
endmodule
`default_nettype wire

// ### testbench/uig_usb_host_model.sv
// usb host model: polls the interrupt endpoint after a chosen gap
`timescale 1ns/10ps
`default_nettype none
module uig_usb_host_model
(
   input  wire logic       clk_in,    // block clock
   input  wire logic       rst_in,    // async reset, high
   input  wire logic       go_in,     // start one poll
   input  wire logic [3:0] gap_in,    // idle cycles before the poll
   output var  logic       poll_out,  // one-cycle poll pulse
   output var  logic       busy_out   // poll in progress
);
   logic       act_q;
   logic [3:0] cnt_q;
   // ******
   // poll sequencer
   // ******
   // one pulse per interval, so the endpoint never sees a poll twice
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         act_q    <= 1'b0;
         cnt_q    <= 4'h0;
         poll_out <= 1'b0;
      end
      else
      begin
         poll_out <= act_q && (cnt_q == 4'h0);
         if (go_in && !act_q)
         begin
            act_q <= 1'b1;
            cnt_q <= gap_in;
         end
         else if (act_q && (cnt_q == 4'h0))
            act_q <= 1'b0;
         else if (act_q)
            cnt_q <= cnt_q - 4'h1;
      end
   end
   // busy covers the pulse itself
   assign busy_out = act_q | poll_out;
endmodule
`default_nettype wire

// ### testbench/tb_usb_int_ep_event_gating.sv
// self-checking bench of the interrupt endpoint event gating block
`timescale 1ns/10ps
`default_nettype none
module tb_usb_int_ep_event_gating;
   import uig_pkg::*;
   logic         mclk_in;
   logic         sys_rst_in;
   uig_ahb_req_t ahb_req;
   uig_ahb_rsp_t ahb_rsp;
   uig_evt_t     evt;
   logic [15:0]  link_chg;
   logic         poll;
   uig_report_t  report;
   logic         sp_req;
   logic         sp_grant;
   logic         go;
   logic [3:0]   gap;
   logic         busy;
   logic         rd_sample;
   logic         grant_q;
   logic [15:0]  wait_cnt;
   logic [31:0]  m;
   logic [31:0]  w;
   int           n_errors;
   int           num_checks;
   logic [32:0]  q_rd[$];
   uig_report_t  q_rep[$];
   logic [15:0]  q_lat[$];
   // ******
   // design and host model
   // ******
   uig_top i_uig_top
   (
      .mclk_in             (mclk_in),
      .sys_rst_in          (sys_rst_in),
      .ahb_req_in          (ahb_req),
      .ahb_rsp_out         (ahb_rsp),
      .events_in           (evt),
      .link_change_in      (link_chg),
      .poll_in             (poll),
      .report_out          (report),
      .short_pkt_req_in    (sp_req),
      .short_pkt_grant_out (sp_grant)
   );
   uig_usb_host_model i_uig_usb_host_model
   (
      .clk_in   (mclk_in),
      .rst_in   (sys_rst_in),
      .go_in    (go),
      .gap_in   (gap),
      .poll_out (poll),
      .busy_out (busy)
   );
   // 100 MHz clock
   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // ******
   // verdict and comparisons
   // ******
   task automatic end_sim();
      if (n_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // a wait that ran out ends the run as a mismatch
   task automatic tmo(input logic ok);
      if (ok !== 1'b1)
      begin
         n_errors++;
         end_sim();
      end
   endtask
   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // each compare takes the oldest note; an empty queue is a mismatch
   task automatic chk_rd(input logic [32:0] got);
      cmp(34'(got), (q_rd.size() > 0) ? 34'(q_rd.pop_front()) : ~34'(got));
   endtask
   task automatic chk_rep(input uig_report_t got);
      cmp(34'(got), (q_rep.size() > 0) ? 34'(q_rep.pop_front()) : ~34'(got));
   endtask
   task automatic chk_lat(input logic [15:0] got);
      cmp(34'(got), (q_lat.size() > 0) ? 34'(q_lat.pop_front()) : ~34'(got));
   endtask
   // ******
   // drivers
   // ******
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
      tmo(ahb_rsp.hreadyout === 1'b1);
   endtask
   // single word transfer: address phase held until ready, then data phase
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      ahb_req.hsel   <= 1'b1;
      ahb_req.haddr  <= addr;
      ahb_req.htrans <= 2'b10;
      ahb_req.hwrite <= wr;
      ahb_req.hsize  <= 3'b010;
      wait_ready();
      ahb_req.hsel   <= 1'b0;
      ahb_req.htrans <= 2'b00;
      ahb_req.hwdata <= data;
      rd_sample      <= !wr;
      wait_ready();
      rd_sample      <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
      q_rd.push_back({1'b0, exp}); // response okay with the data
      bus(1'b0, addr, 32'h0000_0000);
   endtask
   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      bus(1'b1, addr, data);
   endtask
   function automatic uig_report_t exp_rep(input logic [31:0] m_v, input logic [31:0] pend);
      uig_report_t r;
      r.send   = m_v[31] | (pend != 32'h0000_0000);
      r.nak    = ~r.send;
      r.events = pend;
      return r;
   endfunction
   // one-cycle event pulse on the inputs named by the mask bit positions of w_v
   task automatic fire(input logic [31:0] w_v);
      evt      <= uig_evt_t'({w_v[28], w_v[26:21], w_v[19:12], w_v[7:0]});
      link_chg <= w_v[20] ? (16'($urandom) | 16'(1 << $urandom_range(0, 15))) : 16'h0000;
      @(posedge mclk_in);
      evt      <= '0;
      link_chg <= 16'h0000;
   endtask
   // host poll with a random gap, expected report noted first
   task automatic do_poll(input uig_report_t exp);
      int n;
      q_rep.push_back(exp);
      gap <= 4'($urandom_range(0, 3));
      go  <= 1'b1;
      @(posedge mclk_in);
      go  <= 1'b0;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (busy && n < 30);
      tmo(!busy);
   endtask
   // request a short packet; grant expected after ceil(n*16.667/10)+1 edges
   task automatic hold(input logic [15:0] n_steps);
      int n;
      q_lat.push_back(16'((int'(n_steps) * 16667 + 9999) / 10000 + 1));
      sp_req <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (sp_grant !== 1'b1 && n < 5000);
      tmo(sp_grant === 1'b1);
      sp_req <= 1'b0;
      repeat (2) @(posedge mclk_in);
   endtask
   // ******
   // monitor of read data, reports and grant latency
   // ******
   always @(posedge mclk_in)
   begin
      if (rd_sample && ahb_rsp.hreadyout === 1'b1)
         chk_rd({ahb_rsp.hresp, ahb_rsp.hrdata});
      if (report.send === 1'b1 || report.nak === 1'b1)
         chk_rep(report);
      wait_cnt <= (sp_req === 1'b1) ? wait_cnt + 16'h0001 : 16'h0000;
      grant_q  <= sp_grant;
      if (sp_grant === 1'b1 && grant_q === 1'b0)
         chk_lat(wait_cnt);
   end
   // ******
   // main sequence
   // ******
   initial
   begin
      ahb_req    = '0;
      evt        = '0;
      link_chg   = 16'h0000;
      go         = 1'b0;
      gap        = 4'h0;
      sp_req     = 1'b0;
      rd_sample  = 1'b0;
      n_errors   = 0;
      num_checks = 0;
      sys_rst_in = 1'b1;
      void'($urandom(32'h8363));
      repeat (3) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      // hold-off at its reset value, then register reset values and access
      hold(16'h0800);
      rd(UIG_HOLDOFF_ADDR, 32'h0000_0800);
      rd(UIG_MASK_ADDR, 32'h0000_0000);
      wr(UIG_MASK_ADDR, 32'hFFFF_FFFF);
      rd(UIG_MASK_ADDR, 32'h97FF_F0FF);
      wr(UIG_HOLDOFF_ADDR, 32'hFFFF_FFFF);
      rd(UIG_HOLDOFF_ADDR, 32'h0000_FFFF);
      rd(32'h0000_009C, 32'h0000_0000);
      // short hold-off values at the low boundary and one random value
      for (int i = 0; i < 5; i++)
      begin
         m = (i < 4) ? 32'(i) : 32'($urandom_range(4, 60));
         wr(UIG_HOLDOFF_ADDR, m);
         hold(m[15:0]);
      end
      // aborted request must restart the count from zero
      wr(UIG_HOLDOFF_ADDR, 32'h0000_0005);
      sp_req <= 1'b1;
      repeat (3) @(posedge mclk_in);
      sp_req <= 1'b0;
      repeat (2) @(posedge mclk_in);
      hold(16'h0005);
      // each enable alone lets its event through, all others cannot
      for (int p = 0; p < 32; p++)
      begin
         for (int en = 0; en < 2; en++)
         begin
            if (UIG_EVT_BITS[p])
            begin
               m = (en == 1) ? (32'h1 << p) : (UIG_EVT_BITS & ~(32'h1 << p));
               wr(UIG_MASK_ADDR, m);
               fire(32'h1 << p);
               do_poll(exp_rep(m, m & (32'h1 << p)));
            end
         end
      end
      // random masks and events, latched until a poll, force bit included
      for (int i = 0; i < 40; i++)
      begin
         m = $urandom;
         w = $urandom & UIG_EVT_BITS;
         wr(UIG_MASK_ADDR, m);
         fire(w);
         repeat ($urandom_range(0, 4)) @(posedge mclk_in);
         rd(UIG_PEND_ADDR, w & m & UIG_EVT_BITS);
         do_poll(exp_rep(m, w & m & UIG_EVT_BITS));
         do_poll(exp_rep(m, 32'h0000_0000));
      end
      // second reset in mid-run restores both registers
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      rd(UIG_MASK_ADDR, 32'h0000_0000);
      rd(UIG_HOLDOFF_ADDR, 32'h0000_0800);
      @(posedge mclk_in);
      // a result that never came leaves its note behind
      if (q_rd.size() + q_rep.size() + q_lat.size() != 0)
         n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
